// >>> common/piso_pkg.sv
// shared constants, register map and pin carrier for the parallel-in serial-out shifter
package piso_pkg;

  // shift chain geometry
  localparam int STAGE_COUNT = 8;       // number of stages in the chain
  localparam int LAST_STAGE = STAGE_COUNT - 1; // stage that drives the serial output
  localparam int SYNC_DEPTH = 2;        // flip-flops in each pin synchroniser

  // wishbone geometry
  localparam int WB_ADDR_W = 4;         // byte address width of the slave
  localparam int WB_DATA_W = 32;        // data bus width
  localparam int WB_SEL_W = 4;          // byte enables

  // register byte offsets
  localparam logic [WB_ADDR_W-1:0] REG_CTRL = 4'h0;     // source select and soft pin levels
  localparam logic [WB_ADDR_W-1:0] REG_LOAD_DATA = 4'h4; // soft parallel byte
  localparam logic [WB_ADDR_W-1:0] REG_STAGES = 4'h8;   // chain contents, read only

  // control register fields
  localparam int CTRL_SRC_SOFT = 0;     // 1: control pins come from this register
  localparam int CTRL_SHIFT_NOT_LOAD = 1; // soft shift_not_load level
  localparam int CTRL_CLOCK = 2;        // soft shift clock level
  localparam int CTRL_CLOCK_INHIBIT = 3; // soft clock_inhibit level
  localparam int CTRL_SERIAL_IN = 4;    // soft serial_in level
  localparam int CTRL_WIDTH = 5;        // implemented control bits

  // stages register fields
  localparam int STAT_SERIAL_OUT = 8;   // copy of the true serial output
  localparam int STAT_SERIAL_OUT_INV = 9; // copy of the complemented output

  // reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h02; // pins selected, soft mode parked in shift
  localparam logic [STAGE_COUNT-1:0] STAGES_RESET = 8'h00;
  localparam logic [WB_DATA_W-1:0] WB_DATA_ZERO = 32'h0000_0000;

  // levels arriving on the device pins, packed so they synchronise as one word
  typedef struct packed {
    logic shift_not_load;             // low: parallel load, high: shift enabled
    logic clock;                      // shift clock pin
    logic clock_inhibit;              // clock gate pin, interchangeable with clock
    logic serial_in;                  // feeds the first stage
    logic [STAGE_COUNT-1:0] parallel_in; // one line per stage
  } pin_in_t;

  localparam int PIN_W = $bits(pin_in_t);

endpackage : piso_pkg

// >>> core/pin_sync.sv
// two flip-flop synchroniser for a word of unrelated pin levels
`timescale 1ns/1ns
module pin_sync
  import piso_pkg::*;
#(
  parameter int WIDTH = PIN_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // each bit crosses alone; a word may mix old and new bits for one cycle
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_ff; // first stage, read only by the second
      logic hold_ff; // second stage, safe to use
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_ff <= 1'b0;
          hold_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[gi];
          hold_ff <= meta_ff;
        end
      end
      assign sync_out[gi] = hold_ff;
    end
  endgenerate

endmodule // pin_sync

// >>> core/piso_shifter.sv
// eight-stage parallel-in serial-out shift register with a wishbone control slave
`timescale 1ns/1ns
// Behaviour
// - eight stages shift toward the serial output
// - low shift_not_load copies parallel inputs in
// - load overrides clock, inhibit and serial input
// - clock rising edge shifts when inhibit low
// - inhibit rising edge shifts when clock low
// - complemented output mirrors last stage inverted
// - no edge and shifting keeps everything unchanged
module piso_shifter
  import piso_pkg::*;
#(
  parameter int STAGES = STAGE_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  // device pins, unrelated to clk
  input wire logic shift_not_load,
  input wire logic clock,
  input wire logic clock_inhibit,
  input wire logic serial_in,
  input wire logic [STAGES-1:0] parallel_in,
  output logic serial_out,
  output logic serial_out_inverted,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [WB_SEL_W-1:0] wb_sel_i,
  input wire logic [WB_DATA_W-1:0] wb_dat_i,
  output logic [WB_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o
);

  // pin word before and after the crossing
  pin_in_t pins_raw;
  pin_in_t pins_sync;

  // software view of the control pins
  logic [CTRL_WIDTH-1:0] ctrl_ff;   // source select and soft levels
  logic [STAGES-1:0] load_data_ff;  // soft parallel byte

  // effective inputs after source selection
  logic eff_shift_not_load;
  logic eff_clock;
  logic eff_clock_inhibit;
  logic eff_serial_in;
  logic [STAGES-1:0] eff_parallel;

  // gated clock and its edge
  logic gated_clock;                // clock or inhibit; either may act as the clock
  logic gated_prev_ff;              // gated clock one cycle ago
  logic shift_edge;                 // one-cycle pulse on a valid shift edge

  // shift chain and outputs
  logic [STAGES-1:0] stage_ff;      // stage 0 is the first, STAGES-1 drives the output
  logic [STAGES-1:0] nxt_stage;
  logic serial_inv_ff;              // complement kept in its own flop so the output is registered

  // bus handshake
  logic ack_ff;
  logic [WB_DATA_W-1:0] rdata_ff;
  logic bus_req;                    // new request, not yet acknowledged
  logic bus_write;                  // write commits at the edge the master sees ack

  // gather the pins into one word for the synchroniser
  always_comb begin
    pins_raw.shift_not_load = shift_not_load;
    pins_raw.clock = clock;
    pins_raw.clock_inhibit = clock_inhibit;
    pins_raw.serial_in = serial_in;
    pins_raw.parallel_in = parallel_in;
  end

  // every pin passes two flip-flops before anything looks at it
  pin_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // choose pins or software as the source of the control levels
  always_comb begin
    if (ctrl_ff[CTRL_SRC_SOFT]) begin
      eff_shift_not_load = ctrl_ff[CTRL_SHIFT_NOT_LOAD];
      eff_clock = ctrl_ff[CTRL_CLOCK];
      eff_clock_inhibit = ctrl_ff[CTRL_CLOCK_INHIBIT];
      eff_serial_in = ctrl_ff[CTRL_SERIAL_IN];
      eff_parallel = load_data_ff;
    end else begin
      eff_shift_not_load = pins_sync.shift_not_load;
      eff_clock = pins_sync.clock;
      eff_clock_inhibit = pins_sync.clock_inhibit;
      eff_serial_in = pins_sync.serial_in;
      eff_parallel = pins_sync.parallel_in;
    end
  end

  // clock and inhibit are ORed: a rise of one while the other is low is a clock edge
  assign gated_clock = eff_clock | eff_clock_inhibit;

  // an inhibit raised while the clock is low would look like a shift edge here
  assign shift_edge = gated_clock & ~gated_prev_ff & eff_shift_not_load;

  // remember the gated level; edges that happen during a load are consumed and lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gated_prev_ff <= 1'b0;
    end else begin
      gated_prev_ff <= gated_clock;
    end
  end

  // next value of the chain: load wins, then shift, else hold
  always_comb begin
    if (!eff_shift_not_load) begin
      // stages track the parallel lines for as long as load is held
      nxt_stage = eff_parallel;
    end else if (shift_edge) begin
      // serial_in enters stage 0, every stage takes its predecessor
      nxt_stage = {stage_ff[STAGES-2:0], eff_serial_in};
    end else begin
      nxt_stage = stage_ff;
    end
  end

  // the chain itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_ff <= STAGES_RESET;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // complemented output follows the same next value, so both outputs move together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_inv_ff <= ~STAGES_RESET[LAST_STAGE];
    end else begin
      serial_inv_ff <= ~nxt_stage[STAGES-1];
    end
  end

  assign serial_out = stage_ff[STAGES-1];
  assign serial_out_inverted = serial_inv_ff;

  // a request is answered one cycle after it appears; ack drops the cycle after
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bus_write = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i;

  // acknowledge every address, mapped or not, so the master never hangs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // read data is captured with the request and stands while ack is high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= WB_DATA_ZERO;
    end else if (bus_req) begin
      rdata_ff <= WB_DATA_ZERO;
      unique case (wb_adr_i)
        REG_CTRL: begin
          rdata_ff[CTRL_WIDTH-1:0] <= ctrl_ff;
        end
        REG_LOAD_DATA: begin
          rdata_ff[STAGES-1:0] <= load_data_ff;
        end
        REG_STAGES: begin
          rdata_ff[STAGES-1:0] <= stage_ff;
          rdata_ff[STAT_SERIAL_OUT] <= stage_ff[STAGES-1];
          rdata_ff[STAT_SERIAL_OUT_INV] <= serial_inv_ff;
        end
        default: begin
          // unmapped offsets read as zero
          rdata_ff <= WB_DATA_ZERO;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // control register, low byte lane only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (bus_write && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      ctrl_ff <= wb_dat_i[CTRL_WIDTH-1:0];
    end
  end

  // soft parallel byte, low byte lane only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_data_ff <= STAGES_RESET;
    end else if (bus_write && wb_adr_i == REG_LOAD_DATA && wb_sel_i[0]) begin
      load_data_ff <= wb_dat_i[STAGES-1:0];
    end
  end

endmodule // piso_shifter

// >>> tb/piso_checker.sv
// port checks for the shifter, bound into the design
`timescale 1ns/1ns
module piso_checker
  import piso_pkg::*;
#(
  parameter int STAGES = STAGE_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic shift_not_load,
  input wire logic clock,
  input wire logic clock_inhibit,
  input wire logic [STAGES-1:0] parallel_in,
  input wire logic serial_out,
  input wire logic serial_out_inverted,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [WB_SEL_W-1:0] wb_sel_i,
  input wire logic [WB_DATA_W-1:0] wb_dat_i,
  input wire logic [WB_DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a committed control write, seen from the bus side only
  logic ctrl_wr;
  assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == REG_CTRL && wb_sel_i[0];
  // mirror of the source select: pin checks mean nothing while software drives the chain
  logic soft_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_ff <= CTRL_RESET[CTRL_SRC_SOFT];
    end else if (ctrl_wr) begin
      soft_ff <= wb_dat_i[CTRL_SRC_SOFT];
    end
  end
  // edges of pin mode since reset or any control write: the synchroniser must refill first
  logic [1:0] age_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      age_ff <= 2'h0;
    end else if (ctrl_wr || soft_ff) begin
      age_ff <= 2'h0;
    end else begin
      age_ff <= age_ff + 2'(age_ff != 2'h3);
    end
  end
  AST_INV: assert property (serial_out_inverted != serial_out) else $error("inv");
  AST_LOAD: assert property ((age_ff == 2'h3 && !shift_not_load)[*4] |->
    serial_out == $past(parallel_in[STAGES-1], 3)) else $error("load");
  AST_HOLD: assert property ((age_ff == 2'h3 && shift_not_load && !clock && !clock_inhibit)[*5] |->
    $stable(serial_out)) else $error("hold");
  AST_INH: assert property ((age_ff == 2'h3 && shift_not_load && clock_inhibit)[*5] |->
    $stable(serial_out)) else $error("inh");
  AST_CLK: assert property ((age_ff == 2'h3 && shift_not_load && clock)[*5] |->
    $stable(serial_out)) else $error("clk");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
  AST_ACK1: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack1");
  AST_UNMAP: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'hc |-> wb_dat_o == WB_DATA_ZERO)
    else $error("unmap");
endmodule // piso_checker
bind piso_shifter piso_checker #(.STAGES(STAGES)) u_checker (.*);

// >>> tb/pin_driver.sv
// controller model driving the shifter pins as one word
`timescale 1ns/1ns
module pin_driver
  import piso_pkg::*;
(
  input wire logic clk,
  output pin_in_t pins
);
  // park in load, all low, so release shows no edge
  initial pins = '0;
  // change after an edge, hold past the three edges the pins need
  task automatic put(input pin_in_t v);
    @(posedge clk);
    pins <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule // pin_driver

// >>> tb/testbench.sv
// bench for the parallel-in serial-out shifter
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("Error %s %0h %0h", n, e, g); end end
module testbench
  import piso_pkg::*;
;
  logic clk, reset_n, cyc, stb, we, sout, sout_inv, ack;
  logic [WB_ADDR_W-1:0] adr;
  logic [WB_SEL_W-1:0] sel; // byte enables, lane 0 gates every write
  logic [WB_DATA_W-1:0] dat, rd, q;
  logic [7:0] e;
  pin_in_t p, pins;
  int errors, n_checks;
  // {shift expected, inhibit, clock}; inhibit rises with clock high except the last pulse
  logic [2:0] st [8] = '{3'h5, 3'h3, 3'h2, 3'h3, 3'h2, 3'h0, 3'h6, 3'h0};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  piso_shifter u_dut (.clk(clk), .reset_n(reset_n), .shift_not_load(pins.shift_not_load), .clock(pins.clock),
    .clock_inhibit(pins.clock_inhibit), .serial_in(pins.serial_in), .parallel_in(pins.parallel_in),
    .serial_out(sout), .serial_out_inverted(sout_inv), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack));
  pin_driver u_drv (.clk(clk), .pins(pins));
  // classic cycle: hold until ack is sampled, then release
  // no cycle count is assumed: a slave that never answers is caught by the watchdog
  task automatic wb(input logic w, input logic [WB_ADDR_W-1:0] a, input logic [WB_DATA_W-1:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask
  // chain contents through the bus and on the pins
  task automatic see(input logic [7:0] x);
    wb(1'b0, REG_STAGES, '0);
    `CHK("stages", {22'h0, ~x[7], x[7], x}, q)
    `CHK("sout", x[7], sout)
    `CHK("sout_inv", ~x[7], sout_inv)
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // the run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    {reset_n, cyc, stb, we, adr, dat, p} = '0;
    sel = 4'hf;
    e = 8'ha5;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, REG_CTRL, '0);
    `CHK("ctrl", 32'(CTRL_RESET), q)
    wb(1'b1, REG_STAGES, 32'h0000_00ff);
    see(8'h00);
    wb(1'b1, 4'hc, 32'h0000_00ff);
    wb(1'b0, 4'hc, '0);
    `CHK("unmapped", WB_DATA_ZERO, q)
    wb(1'b1, REG_LOAD_DATA, 32'h0000_003c);
    wb(1'b0, REG_LOAD_DATA, '0);
    `CHK("load_data", 32'h0000_003c, q)
    // a write without lane 0 must leave the byte alone
    sel <= 4'he;
    wb(1'b1, REG_LOAD_DATA, 32'h0000_00ff);
    sel <= 4'hf;
    wb(1'b0, REG_LOAD_DATA, '0);
    `CHK("load_data_sel", 32'h0000_003c, q)
    $display("test registers done");
    // load wins while the clock sits high
    p.clock = 1'b1;
    p.parallel_in = e;
    u_drv.put(p);
    see(e);
    {p.shift_not_load, p.clock} = 2'b10;
    u_drv.put(p);
    see(e);
    // sixteen clock levels give eight shifts of a mixed pattern
    for (int i = 0; i < 16; i++) begin
      {p.serial_in, p.clock} = {i[1] ^ i[3], ~i[0]};
      u_drv.put(p);
      if (!i[0]) e = {e[6:0], p.serial_in};
      `CHK("sout", e[7], sout)
    end
    p.serial_in = 1'b1;
    foreach (st[i]) begin
      {p.clock_inhibit, p.clock} = st[i][1:0];
      u_drv.put(p);
      if (st[i][2]) e = {e[6:0], 1'b1};
      see(e);
    end
    $display("test pins done");
    // soft source: register levels drive the chain, pins are ignored
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    see(8'h3c);
    wb(1'b1, REG_CTRL, 32'h0000_0003);
    see(8'h3c);
    wb(1'b1, REG_CTRL, 32'h0000_0007);
    see(8'h78);
    wb(1'b1, REG_CTRL, 32'h0000_0013);
    wb(1'b1, REG_CTRL, 32'h0000_0017);
    see(8'hf1);
    // back to the pins with both clock levels low, so no false edge
    wb(1'b1, REG_CTRL, 32'h0000_0002);
    see(8'hf1);
    $display("test soft source done");
    complete_run();
  end
endmodule // testbench
